// ===== ocg_pkg.sv
// shared constants and types for the oscillator wait and clock gating block
package ocg_pkg;

  // register indices; the byte address on the bus is four times the index
  localparam logic [15:0] IDX_AUX_B_CTRL = 16'h5065; // aux clock b control
  localparam logic [15:0] IDX_OSC_WAIT = 16'h507D; // osc_stabilization_wait
  localparam logic [15:0] IDX_PCLK_GATE = 16'h5080; // peripheral_clock_gate
  localparam logic [15:0] IDX_CORE_GEAR = 16'h5081; // core_clock_gear

  // field positions inside the byte-wide registers
  localparam int unsigned FAST_WAIT_LSB = 6; // fast_osc_wait_select [7:6]
  localparam int unsigned SLOW_WAIT_LSB = 0; // slow_osc_wait_select [1:0]
  localparam int unsigned PCLK_EN_LSB = 0; // peripheral_clock_enable [1:0]
  localparam int unsigned GEAR_LSB = 0; // core_clock_gear_select [1:0]
  localparam int unsigned AUX_B_EN_BIT = 0; // aux_clock_b_output_enable

  // values after reset
  localparam logic [1:0] FAST_WAIT_RST = 2'h0; // 64 cycles
  localparam logic [1:0] SLOW_WAIT_RST = 2'h0; // 16384 cycles
  localparam logic [1:0] PCLK_EN_RST = 2'h3; // peripheral clock on
  localparam logic [1:0] GEAR_RST = 2'h0; // core at 1/1
  localparam logic AUX_B_EN_RST = 1'b0; // aux output b stopped

  // field codes
  localparam logic [1:0] PCLK_ON = 2'h3; // supply peripheral clock
  localparam logic [1:0] SLOW_WAIT_SHORT_CODE = 2'h2; // 4096 cycles

  // wait counts in oscillator cycles
  localparam int unsigned FAST_CNT_W = 7;
  localparam int unsigned SLOW_CNT_W = 15;
  localparam logic [FAST_CNT_W-1:0] FAST_WAIT_8 = 7'h08;
  localparam logic [FAST_CNT_W-1:0] FAST_WAIT_16 = 7'h10;
  localparam logic [FAST_CNT_W-1:0] FAST_WAIT_32 = 7'h20;
  localparam logic [FAST_CNT_W-1:0] FAST_WAIT_64 = 7'h40;
  localparam int unsigned SLOW_WAIT_SHORT_CYC = 4096;
  localparam int unsigned SLOW_WAIT_LONG_CYC = 16384;

  // bus geometry
  localparam int unsigned AVS_ADDR_W = 18; // byte address
  localparam int unsigned AVS_DATA_W = 32;

  // avalon request from the master
  typedef struct packed {
    logic read;
    logic write;
    logic [AVS_ADDR_W-1:0] address;
    logic [AVS_DATA_W-1:0] writedata;
    logic [3:0] byteenable;
  } ocg_avs_req_t;

  // oscillator status toward the system
  typedef struct packed {
    logic on; // oscillator running
    logic tick; // one pulse per oscillator cycle
  } ocg_osc_t;

endpackage

// ===== ocg_wait_counter.sv
`timescale 1ns/1ps
`default_nettype none
// counts oscillator ticks after start and flags the clock as stable
module ocg_wait_counter
  import ocg_pkg::*;
#(
  parameter int unsigned CNT_W = 7
)(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire ocg_osc_t i_osc,
  input wire logic [CNT_W-1:0] i_wait_cycles,
  output logic o_stable
);

  logic [CNT_W-1:0] cnt_r; // ticks seen since start
  logic stable_r; // wait has elapsed
  logic last_tick; // this tick completes the wait

  // compare with >= so a shortened selection mid-wait still ends it
  assign last_tick = (cnt_r >= CNT_W'(i_wait_cycles - CNT_W'(1)));

  // wait sequencer
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      cnt_r <= '0;
      stable_r <= 1'b0;
    end
    else if (!i_osc.on)
    begin
      // stopped oscillator restarts the wait
      cnt_r <= '0;
      stable_r <= 1'b0;
    end
    else if (!stable_r && i_osc.tick)
    begin
      if (last_tick)
      begin
        stable_r <= 1'b1; // RULE3 RULE8
        cnt_r <= '0;
      end
      else
      begin
        cnt_r <= CNT_W'(cnt_r + CNT_W'(1));
      end
    end
  end

  assign o_stable = stable_r;

endmodule
`default_nettype wire

// ===== ocg_top.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// RULE1: aux output b enable drives pin, resets 0
// RULE2: fast wait codes 3,2,1,0 = 8,16,32,64
// RULE3: fast clock withheld until wait counted
// RULE4: reset sets fast wait to 64 cycles
// RULE5: cpu runs only after fast wait done
// RULE6: software may pick shortest fast wait later
// RULE7: slow wait 2=4096, 0=16384, others reserved
// RULE8: slow clock withheld until wait counted
// RULE9: reset sets slow wait to 16384 cycles
// RULE10: software shortens slow wait only with care
// RULE11: peripheral enable 3 supplies, 0 stops
// RULE12: peripheral enable resets to 3
// RULE13: software never writes peripheral enable 1 or 2
// RULE14: software stops peripheral clock only when unused
// RULE15: non-peripheral outputs run while peripheral stopped
// RULE16: gear 3,2,1,0 = 1/8,1/4,1/2,1/1, resets 0
// RULE17: software picks slowest adequate core gear
// RULE18: reserved bits read 0, writes ignored
// RULE19: gear and gate changes make no runt pulses
module ocg_top
  import ocg_pkg::*;
#(
  parameter int unsigned SLOW_WAIT_LONG = SLOW_WAIT_LONG_CYC,
  parameter int unsigned SLOW_WAIT_SHORT = SLOW_WAIT_SHORT_CYC
)(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire ocg_avs_req_t i_avs,
  output logic [AVS_DATA_W-1:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire ocg_osc_t i_fast_oscillator,
  input wire ocg_osc_t i_slow_oscillator,
  input wire logic i_aux_clock_b,
  output logic o_fast_osc_ready,
  output logic o_slow_osc_ready,
  output logic o_cpu_run,
  output logic o_core_clock_en,
  output logic o_periph_clock_en,
  output logic o_aux_clock_output_b
);

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  logic [1:0] fast_wait_sel_r; // fast_osc_wait_select
  logic [1:0] slow_wait_sel_r; // slow_osc_wait_select
  logic [1:0] pclk_en_r; // peripheral_clock_enable
  logic [1:0] gear_sel_r; // core_clock_gear_select
  logic aux_b_en_r; // aux_clock_b_output_enable

  // ---------------------------------------------------------------
  // bus slave state
  // ---------------------------------------------------------------
  logic wait_r; // waitrequest, high until answer
  logic [AVS_DATA_W-1:0] rdata_r; // captured read data
  logic req; // read or write pending
  logic wr_fire; // write commits this edge
  logic wr_lane0; // low byte lane enabled
  logic [15:0] idx; // register index from address
  logic [7:0] rd_byte; // byte selected for reading

  // ---------------------------------------------------------------
  // clock output state
  // ---------------------------------------------------------------
  logic fast_stable; // fast wait elapsed
  logic slow_stable; // slow wait elapsed
  logic [FAST_CNT_W-1:0] fast_wait_cyc; // decoded fast wait
  logic [SLOW_CNT_W-1:0] slow_wait_cyc; // decoded slow wait
  logic cpu_run_r; // core released after reset
  logic fast_rdy_r; // registered fast ready
  logic slow_rdy_r; // registered slow ready
  logic [2:0] div_cnt_r; // core divider phase
  logic [1:0] gear_act_r; // gear in force this period
  logic [2:0] div_limit; // last phase of current period
  logic period_end; // divider wraps this cycle
  logic core_en_r; // core clock enable pulse
  logic pclk_on_r; // peripheral clock enable level
  logic aux_out_r; // aux output b pin level

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  // byte address, word aligned; low two bits are ignored
  assign idx = i_avs.address[AVS_ADDR_W-1:2];
  assign req = i_avs.read || i_avs.write;
  // the write lands on the edge that sees waitrequest low
  assign wr_fire = i_avs.write && !wait_r;
  assign wr_lane0 = i_avs.byteenable[0];

  // read mux, reserved bits and unmapped words read zero
  always_comb
  begin
    rd_byte = 8'h00;
    unique case (idx)
      IDX_OSC_WAIT:
      begin
        rd_byte[FAST_WAIT_LSB +: 2] = fast_wait_sel_r; // RULE18
        rd_byte[SLOW_WAIT_LSB +: 2] = slow_wait_sel_r;
      end
      IDX_PCLK_GATE:
      begin
        rd_byte[PCLK_EN_LSB +: 2] = pclk_en_r; // RULE18
      end
      IDX_CORE_GEAR:
      begin
        rd_byte[GEAR_LSB +: 2] = gear_sel_r; // RULE18
      end
      IDX_AUX_B_CTRL:
      begin
        rd_byte[AUX_B_EN_BIT] = aux_b_en_r;
      end
      default:
      begin
        rd_byte = 8'h00; // unmapped address
      end
    endcase
  end

  // ---------------------------------------------------------------
  // avalon handshake: one wait state per access
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      wait_r <= 1'b1;
    end
    else if (req && wait_r)
    begin
      // answer on the next edge
      wait_r <= 1'b0;
    end
    else
    begin
      // back to busy after the answer
      wait_r <= 1'b1;
    end
  end

  // read data captured in the busy cycle, stands in the answer cycle
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      rdata_r <= 32'h0000_0000;
    end
    else if (i_avs.read && wait_r)
    begin
      rdata_r <= {24'h00_0000, rd_byte};
    end
  end

  // ---------------------------------------------------------------
  // register writes; only defined field bits are stored
  // ---------------------------------------------------------------
  // wait selection register
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      fast_wait_sel_r <= FAST_WAIT_RST; // RULE4
      slow_wait_sel_r <= SLOW_WAIT_RST; // RULE9
    end
    else if (wr_fire && wr_lane0 && idx == IDX_OSC_WAIT)
    begin
      // bits 5:2 are dropped here
      fast_wait_sel_r <= i_avs.writedata[FAST_WAIT_LSB +: 2]; // RULE18
      slow_wait_sel_r <= i_avs.writedata[SLOW_WAIT_LSB +: 2];
    end
  end

  // peripheral clock gate register
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      pclk_en_r <= PCLK_EN_RST; // RULE12
    end
    else if (wr_fire && wr_lane0 && idx == IDX_PCLK_GATE)
    begin
      pclk_en_r <= i_avs.writedata[PCLK_EN_LSB +: 2]; // RULE18
    end
  end

  // core gear register
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      gear_sel_r <= GEAR_RST; // RULE16
    end
    else if (wr_fire && wr_lane0 && idx == IDX_CORE_GEAR)
    begin
      gear_sel_r <= i_avs.writedata[GEAR_LSB +: 2]; // RULE18
    end
  end

  // aux output b enable register
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      aux_b_en_r <= AUX_B_EN_RST; // RULE1
    end
    else if (wr_fire && wr_lane0 && idx == IDX_AUX_B_CTRL)
    begin
      aux_b_en_r <= i_avs.writedata[AUX_B_EN_BIT]; // RULE1
    end
  end

  // ---------------------------------------------------------------
  // stabilization wait decode
  // ---------------------------------------------------------------
  // fast oscillator wait length
  always_comb
  begin
    unique case (fast_wait_sel_r)
      2'h3: fast_wait_cyc = FAST_WAIT_8; // RULE2
      2'h2: fast_wait_cyc = FAST_WAIT_16; // RULE2
      2'h1: fast_wait_cyc = FAST_WAIT_32; // RULE2
      2'h0: fast_wait_cyc = FAST_WAIT_64; // RULE2
    endcase
  end

  // slow oscillator wait; reserved codes fall back to the long wait
  always_comb
  begin
    if (slow_wait_sel_r == SLOW_WAIT_SHORT_CODE)
    begin
      slow_wait_cyc = SLOW_CNT_W'(SLOW_WAIT_SHORT); // RULE7
    end
    else
    begin
      slow_wait_cyc = SLOW_CNT_W'(SLOW_WAIT_LONG); // RULE7
    end
  end

  // fast oscillator wait counter
  ocg_wait_counter #(
    .CNT_W(FAST_CNT_W)
  ) u_fast_wait (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_osc(i_fast_oscillator),
    .i_wait_cycles(fast_wait_cyc),
    .o_stable(fast_stable)
  );

  // slow oscillator wait counter
  ocg_wait_counter #(
    .CNT_W(SLOW_CNT_W)
  ) u_slow_wait (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_osc(i_slow_oscillator),
    .i_wait_cycles(slow_wait_cyc),
    .o_stable(slow_stable)
  );

  // ready flags toward the system clock switch
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      fast_rdy_r <= 1'b0;
      slow_rdy_r <= 1'b0;
    end
    else
    begin
      fast_rdy_r <= fast_stable; // RULE3
      slow_rdy_r <= slow_stable; // RULE8
    end
  end

  // core release: once set, stays until the next reset
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      cpu_run_r <= 1'b0;
    end
    else if (fast_stable)
    begin
      cpu_run_r <= 1'b1; // RULE5
    end
  end

  // ---------------------------------------------------------------
  // core clock gear divider
  // ---------------------------------------------------------------
  // ratio 2^gear, so the last phase is 2^gear - 1
  assign div_limit = 3'((4'h1 << gear_act_r) - 4'h1);
  assign period_end = (div_cnt_r == div_limit);

  // divider; new gear is adopted only at a period boundary
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      div_cnt_r <= 3'h0;
      gear_act_r <= GEAR_RST;
    end
    else if (period_end)
    begin
      div_cnt_r <= 3'h0;
      gear_act_r <= gear_sel_r; // RULE19
    end
    else
    begin
      div_cnt_r <= 3'(div_cnt_r + 3'h1); // RULE16
    end
  end

  // one enable pulse per whole period, only once the core is released
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      core_en_r <= 1'b0;
    end
    else
    begin
      core_en_r <= cpu_run_r && period_end; // RULE5 RULE16
    end
  end

  // ---------------------------------------------------------------
  // peripheral clock gate
  // ---------------------------------------------------------------
  // level enable changes on a clock edge, so no partial pulse
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      pclk_on_r <= 1'b1;
    end
    else
    begin
      // codes 1 and 2 are treated as off
      pclk_on_r <= (pclk_en_r == PCLK_ON); // RULE11 RULE19
    end
  end

  // ---------------------------------------------------------------
  // aux clock output b; independent of the peripheral gate
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      aux_out_r <= 1'b0;
    end
    else
    begin
      aux_out_r <= aux_b_en_r && i_aux_clock_b; // RULE1 RULE15
    end
  end

  // ---------------------------------------------------------------
  // outputs, all from flip-flops
  // ---------------------------------------------------------------
  assign o_avs_readdata = rdata_r;
  assign o_avs_waitrequest = wait_r;
  assign o_fast_osc_ready = fast_rdy_r;
  assign o_slow_osc_ready = slow_rdy_r;
  assign o_cpu_run = cpu_run_r;
  assign o_core_clock_en = core_en_r;
  assign o_periph_clock_en = pclk_on_r;
  assign o_aux_clock_output_b = aux_out_r;

endmodule
`default_nettype wire

// ===== ocg_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// port-level checks for the oscillator wait and clock gating block
module ocg_checker
  import ocg_pkg::*;
#(
  parameter int unsigned SLOW_WAIT_LONG = 16384,
  parameter int unsigned SLOW_WAIT_SHORT = 4096
)(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire ocg_avs_req_t i_avs,
  input wire logic [AVS_DATA_W-1:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  input wire ocg_osc_t i_fast_oscillator,
  input wire ocg_osc_t i_slow_oscillator,
  input wire logic i_aux_clock_b,
  input wire logic o_fast_osc_ready,
  input wire logic o_slow_osc_ready,
  input wire logic o_cpu_run,
  input wire logic o_core_clock_en,
  input wire logic o_periph_clock_en,
  input wire logic o_aux_clock_output_b
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  logic cmt; // write commits at this edge
  logic [7:0] wd; // written byte
  logic [7:0] wait_r; // wait register mirror
  logic [1:0] gear_r; // gear mirror
  logic [1:0] gold_r; // gear before last write
  logic aux_r; // aux enable mirror
  logic [15:0] fc_r; // fast ticks since start
  logic [15:0] sc_r; // slow ticks since start
  logic [3:0] gap_r; // cycles since last core pulse
  logic seen_r; // a core pulse was seen
  int unsigned fw; // selected fast wait
  int unsigned sw; // selected slow wait
  assign cmt = i_avs.write && !o_avs_waitrequest && i_avs.byteenable[0];
  assign wd = i_avs.writedata[7:0];
  assign fw = 32'h40 >> wait_r[7:6];
  assign sw = (wait_r[1:0] == 2'h2) ? SLOW_WAIT_SHORT : SLOW_WAIT_LONG;
  // address match for a register index
  function automatic logic at(input logic [15:0] idx);
    return i_avs.address == {idx, 2'h0};
  endfunction
  // register mirrors, reserved bits dropped
  always_ff @(posedge i_clk or posedge i_sys_rst)
    if (i_sys_rst)
    begin
      wait_r <= 8'h00;
      gear_r <= 2'h0;
      gold_r <= 2'h0;
      aux_r <= 1'b0;
    end
    else if (cmt)
    begin
      if (at(IDX_OSC_WAIT))
        wait_r <= wd & 8'hC3;
      if (at(IDX_CORE_GEAR))
      begin
        gear_r <= wd[1:0];
        gold_r <= gear_r;
      end
      if (at(IDX_AUX_B_CTRL))
        aux_r <= wd[0];
    end
  // tick counts and core pulse spacing
  always_ff @(posedge i_clk or posedge i_sys_rst)
    if (i_sys_rst)
    begin
      fc_r <= 16'h0;
      sc_r <= 16'h0;
      gap_r <= 4'h0;
      seen_r <= 1'b0;
    end
    else
    begin
      fc_r <= i_fast_oscillator.on ?
        fc_r + 16'(i_fast_oscillator.tick) : 16'h0;
      sc_r <= i_slow_oscillator.on ?
        sc_r + 16'(i_slow_oscillator.tick) : 16'h0;
      gap_r <= o_core_clock_en ? 4'h1 : gap_r + 4'(gap_r != 4'hF);
      seen_r <= seen_r || o_core_clock_en;
    end
  property p_aux;
    o_aux_clock_output_b == ($past(aux_r) && $past(i_aux_clock_b));
  endproperty
  a_aux: assert property (p_aux) else $error("aux out wrong");
  property p_fast_early;
    $rose(o_fast_osc_ready) |-> fc_r >= fw;
  endproperty
  a_fast_early: assert property (p_fast_early) else $error("fast early");
  property p_fast_late;
    i_fast_oscillator.on && i_fast_oscillator.tick && fc_r >= fw
      |-> ##[1:3] o_fast_osc_ready;
  endproperty
  a_fast_late: assert property (p_fast_late) else $error("fast late");
  property p_slow_early;
    $rose(o_slow_osc_ready) |-> sc_r >= sw;
  endproperty
  a_slow_early: assert property (p_slow_early) else $error("slow early");
  property p_slow_late;
    i_slow_oscillator.on && i_slow_oscillator.tick && sc_r >= sw
      |-> ##[1:3] o_slow_osc_ready;
  endproperty
  a_slow_late: assert property (p_slow_late) else $error("slow late");
  property p_cpu_start;
    $rose(o_cpu_run) |-> $rose(o_fast_osc_ready);
  endproperty
  a_cpu_start: assert property (p_cpu_start) else $error("cpu start");
  property p_core_run;
    o_core_clock_en |-> o_cpu_run;
  endproperty
  a_core_run: assert property (p_core_run) else $error("core en");
  property p_core_period;
    o_core_clock_en && seen_r
      |-> gap_r == 4'(1 << gear_r) || gap_r == 4'(1 << gold_r);
  endproperty
  a_core_period: assert property (p_core_period) else $error("gear");
  property p_pclk;
    cmt && at(IDX_PCLK_GATE)
      |-> ##2 o_periph_clock_en == ($past(wd[1:0], 2) == 2'h3);
  endproperty
  a_pclk: assert property (p_pclk) else $error("pclk enable");
  property p_bus;
    (i_avs.read || i_avs.write) && o_avs_waitrequest
      |=> !o_avs_waitrequest ##1 o_avs_waitrequest;
  endproperty
  a_bus: assert property (p_bus) else $error("bus answer");
  property p_rd_wait;
    i_avs.read && !o_avs_waitrequest && at(IDX_OSC_WAIT)
      |-> o_avs_readdata == {24'h0, wait_r};
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("wait read");
  c_run: cover property ($rose(o_cpu_run));
  c_pclk_off: cover property (!o_periph_clock_en);
  c_gear8: cover property (o_core_clock_en && gear_r == 2'h3);
endmodule
bind ocg_top ocg_checker #(
  .SLOW_WAIT_LONG(SLOW_WAIT_LONG), .SLOW_WAIT_SHORT(SLOW_WAIT_SHORT)
) u_chk (
  .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_avs(i_avs),
  .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
  .i_fast_oscillator(i_fast_oscillator),
  .i_slow_oscillator(i_slow_oscillator), .i_aux_clock_b(i_aux_clock_b),
  .o_fast_osc_ready(o_fast_osc_ready), .o_slow_osc_ready(o_slow_osc_ready),
  .o_cpu_run(o_cpu_run), .o_core_clock_en(o_core_clock_en),
  .o_periph_clock_en(o_periph_clock_en),
  .o_aux_clock_output_b(o_aux_clock_output_b)
);
`default_nettype wire

// ===== ocg_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ocg_top_tb
  import ocg_pkg::*;
;
  localparam int SL = 40; // shortened long slow wait
  localparam int SS = 10; // shortened short slow wait
  logic i_clk;
  logic i_sys_rst;
  logic i_aux_clock_b;
  ocg_avs_req_t avs;
  ocg_osc_t fo;
  ocg_osc_t so;
  logic [31:0] rd; // bus read data
  logic wreq;
  logic fr;
  logic sr;
  logic run;
  logic cen;
  logic pen;
  logic aux;
  logic [31:0] rdata;
  int fails = 0;
  int cmp_count = 0;
  int cyc = 0;
  ocg_top #(.SLOW_WAIT_LONG(SL), .SLOW_WAIT_SHORT(SS)) dut (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_avs(avs),
    .o_avs_readdata(rd), .o_avs_waitrequest(wreq),
    .i_fast_oscillator(fo), .i_slow_oscillator(so),
    .i_aux_clock_b(i_aux_clock_b), .o_fast_osc_ready(fr),
    .o_slow_osc_ready(sr), .o_cpu_run(run), .o_core_clock_en(cen),
    .o_periph_clock_en(pen), .o_aux_clock_output_b(aux)
  );
  always #4 i_clk = ~i_clk;
  // oscillator ticks every second cycle, plus hang guard
  always @(posedge i_clk)
  begin
    fo.tick <= fo.on && !fo.tick;
    so.tick <= so.on && !so.tick;
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fails++;
      tally_and_finish;
    end
  end
  task automatic tally_and_finish;
    $display("fails %0d cmp_count %0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, logic [31:0] s);
    cmp_count++;
    if (s !== e)
    begin
      fails++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  // one avalon access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [15:0] idx,
    input logic [7:0] d, input logic be);
    int n;
    @(posedge i_clk);
    avs.read <= !wr;
    avs.write <= wr;
    avs.address <= {idx, 2'h0};
    avs.writedata <= {24'h0, d};
    avs.byteenable <= be ? 4'hF : 4'h0;
    n = 0;
    do
    begin
      @(posedge i_clk);
      n++;
    end
    while (wreq !== 1'b0);
    rdata = rd;
    avs.read <= 1'b0;
    avs.write <= 1'b0;
    // taken on the first edge, answered on the second
    chk("bus answer", 32'h2, n);
  endtask
  task automatic t_reset;
    chk("periph en", 32'h1, pen);
    chk("cpu run", 32'h0, run);
    bus(0, IDX_OSC_WAIT, 8'h00, 1);
    chk("wait reset", 32'h0, rdata);
    bus(0, IDX_PCLK_GATE, 8'h00, 1);
    chk("pclk reset", 32'h3, rdata);
    bus(0, IDX_CORE_GEAR, 8'h00, 1);
    chk("gear reset", 32'h0, rdata);
    bus(0, IDX_AUX_B_CTRL, 8'h00, 1);
    chk("aux reset", 32'h0, rdata);
  endtask
  // start one oscillator and count ticks until it is released
  task automatic t_wait(input logic slow, input logic [7:0] w, input int n);
    int t;
    int k;
    bus(1, IDX_OSC_WAIT, w, 1);
    t = 0;
    k = 0;
    so.on <= slow;
    fo.on <= !slow;
    while ((slow ? sr : fr) !== 1'b1 && k < 400)
    begin
      @(posedge i_clk);
      k++;
      t += int'(slow ? so.tick : fo.tick);
    end
    cmp_count++;
    if (t < n || t > n + 1)
    begin
      fails++;
      $display("[ERR] wait ticks exp %0d got %0d", n, t);
    end
    so.on <= 1'b0;
    fo.on <= 1'b0;
    repeat (4) @(posedge i_clk);
    chk("ready drop", 32'h0, slow ? sr : fr);
  endtask
  task automatic t_regs;
    bus(1, IDX_OSC_WAIT, 8'hFF, 1);
    bus(0, IDX_OSC_WAIT, 8'h00, 1);
    chk("wait reserved", 32'hC3, rdata);
    bus(1, IDX_CORE_GEAR, 8'hFC, 1);
    bus(0, IDX_CORE_GEAR, 8'h00, 1);
    chk("gear reserved", 32'h0, rdata);
    // low byte lane off: write must be ignored
    bus(1, IDX_CORE_GEAR, 8'h03, 0);
    bus(0, IDX_CORE_GEAR, 8'h00, 1);
    chk("lane off", 32'h0, rdata);
    bus(1, 16'h5070, 8'hFF, 1);
    bus(0, 16'h5070, 8'h00, 1);
    chk("unmapped", 32'h0, rdata);
  endtask
  // peripheral gate off and on, aux output keeps running
  task automatic t_pclk_aux;
    bus(1, IDX_AUX_B_CTRL, 8'h01, 1);
    bus(1, IDX_PCLK_GATE, 8'hFC, 1);
    repeat (2) @(posedge i_clk);
    chk("pclk off", 32'h0, pen);
    for (int i = 0; i < 4; i++)
    begin
      i_aux_clock_b <= !i[0];
      repeat (2) @(posedge i_clk);
      chk("aux out", 32'(!i[0]), aux);
    end
    bus(1, IDX_PCLK_GATE, 8'h03, 1);
    repeat (2) @(posedge i_clk);
    chk("pclk on", 32'h1, pen);
    i_aux_clock_b <= 1'b1;
    bus(1, IDX_AUX_B_CTRL, 8'h00, 1);
    repeat (3) @(posedge i_clk);
    chk("aux stop", 32'h0, aux);
  endtask
  // cycles from one core pulse to the next
  task automatic gap(output int p);
    p = 0;
    do
    begin
      @(posedge i_clk);
      p++;
    end
    while (cen !== 1'b1 && p < 20);
  endtask
  task automatic t_gear;
    int p;
    for (int g = 3; g >= 0; g--)
    begin
      bus(1, IDX_CORE_GEAR, 8'(g), 1);
      gap(p);
      gap(p);
      gap(p);
      chk("gear period", 32'h1 << g, p);
    end
  endtask
  // reset in mid-run must restore every register
  task automatic t_rst2;
    bus(1, IDX_PCLK_GATE, 8'h00, 1);
    @(posedge i_clk);
    i_sys_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    t_reset;
  endtask
  initial
  begin
    i_clk = 1'b0;
    i_sys_rst = 1'b1;
    i_aux_clock_b = 1'b0;
    avs = '0;
    fo = '0;
    so = '0;
    repeat (5) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    t_reset;
    t_wait(0, 8'h00, 64);
    chk("cpu run", 32'h1, run);
    t_wait(0, 8'hC0, 8);
    t_wait(0, 8'h80, 16);
    t_wait(0, 8'h40, 32);
    t_wait(1, 8'h00, SL);
    t_wait(1, 8'h02, SS);
    t_wait(1, 8'h01, SL);
    t_wait(1, 8'h03, SL);
    t_regs;
    t_pclk_aux;
    t_gear;
    t_rst2;
    tally_and_finish;
  end
endmodule
`default_nettype wire
